//--- mltr_cfg.svh
// offsets, field positions, reset value and sizes of the tuning register bank
`ifndef MLTR_CFG_SVH
`define MLTR_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define MLTR_IDX_CURRENT_GAIN    8'h8c
`define MLTR_IDX_SPEED_GAIN      8'h8e
`define MLTR_IDX_PROFILE_FIRST   8'h94
`define MLTR_REG_COUNT           3

`define MLTR_RESET_VALUE         32'h0000_0000

// current_gain_cfg fields
`define MLTR_PARITY_BIT          31
`define MLTR_BEMF_MSB            30
`define MLTR_BEMF_LSB            23
`define MLTR_CUR_KP_MSB          22
`define MLTR_CUR_KP_LSB          13
`define MLTR_CUR_KI_MSB          12
`define MLTR_CUR_KI_LSB          3
`define MLTR_SPD_KP_HI_MSB       2
`define MLTR_SPD_KP_HI_LSB       0

// speed_gain_limit_cfg fields
`define MLTR_SPD_KP_LO_MSB       30
`define MLTR_SPD_KP_LO_LSB       24
`define MLTR_SPD_KI_MSB          23
`define MLTR_SPD_KI_LSB          14
`define MLTR_MAX_SPEED_MSB       13
`define MLTR_MAX_SPEED_LSB       0

// profile_duty_cfg_first fields
`define MLTR_PROF_MODE_MSB       30
`define MLTR_PROF_MODE_LSB       29
`define MLTR_DUTY_ON_MSB         28
`define MLTR_DUTY_ON_LSB         21
`define MLTR_DUTY_OFF_MSB        20
`define MLTR_DUTY_OFF_LSB        13
`define MLTR_DUTY_CLAMP_MSB      12
`define MLTR_DUTY_CLAMP_LSB      5
`define MLTR_DUTY_A_HI_MSB       4
`define MLTR_DUTY_A_HI_LSB       0

// gain code layout: low 8 bits mantissa, upper 2 bits decade exponent
`define MLTR_GAIN_MANT_MSB       7
`define MLTR_GAIN_EXP_MSB        9
`define MLTR_GAIN_EXP_LSB        8
`define MLTR_GAIN_COUNT          4

`endif

//--- mltr_gain_split.sv
// splits a 10-bit gain code into mantissa, decade exponent and zero flag
`timescale 1ns/100ps
`include "mltr_cfg.svh"

module mltr_gain_split
    import mltr_pkg::*;
(
    input  wire logic [9:0]    gain_code,
    output mltr_gain_type      gain
);

    // value = scale * mantissa / 10**exponent; scale is fixed per gain
    assign gain.mantissa = gain_code[`MLTR_GAIN_MANT_MSB:0];
    assign gain.exponent = gain_code[`MLTR_GAIN_EXP_MSB:`MLTR_GAIN_EXP_LSB];
    assign gain.zero     = (gain_code == 10'h000);

endmodule

//--- mltr_pkg.sv
// types shared by the tuning register bank and its gain splitter
package mltr_pkg;

    typedef enum logic [1:0] {
        MLTR_PROF_EQUATION,
        MLTR_PROF_LINEAR,
        MLTR_PROF_STAIRCASE,
        MLTR_PROF_FWD_REV
    } mltr_profile_mode_type;

    typedef struct packed {
        logic [7:0] mantissa;
        logic [1:0] exponent;
        logic       zero;
    } mltr_gain_type;

    typedef struct packed {
        logic [7:0]  back_emf_constant_code;
        logic [9:0]  current_prop_gain;
        logic [9:0]  current_integ_gain;
        logic [9:0]  speed_prop_gain;
        logic [9:0]  speed_integ_gain;
        logic [13:0] max_speed_code;
    } mltr_loop_cfg_type;

    typedef struct packed {
        mltr_profile_mode_type mode;
        logic [7:0]            turn_on_duty_threshold;
        logic [7:0]            turn_off_duty_threshold;
        logic [7:0]            clamp_duty_threshold;
        logic [4:0]            duty_a_upper;
    } mltr_profile_cfg_type;

endpackage

//--- mltr_tuning_regs.sv
// closed-loop tuning and first reference-profile registers behind APB
//
// Summary of operation
// RL1: every register resets to all zeros
// RL2: back-EMF constant code in bits 30..23
// RL3: current proportional gain in bits 22..13
// RL4: current integral gain in bits 12..3
// RL5: zero current gain field selects auto calculation
// RL6: speed proportional gain split across two registers
// RL7: speed proportional gain is mantissa over decade
// RL8: speed integral gain in bits 23..14
// RL9: maximum speed code in bits 13..0
// RL10: profile register holds mode and duty thresholds
// RL11: two-bit profile selector picks one of four
// RL12: duty thresholds are eight-bit fractions of 256
// RL13: reads return last written value, no side effects
`timescale 1ns/100ps
`include "mltr_cfg.svh"

module mltr_tuning_regs
    import mltr_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_WIDTH-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    output mltr_loop_cfg_type            loop_cfg,
    output mltr_profile_cfg_type         profile_cfg,
    output mltr_gain_type [`MLTR_GAIN_COUNT-1:0] gain_decoded,
    output logic                         current_gain_auto,
    output logic                         parity_bits [`MLTR_REG_COUNT]
);

    localparam int REG_COUNT = `MLTR_REG_COUNT;

    // the highest byte address is four times the largest index
    if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32) begin : g_addr_check
        $error("ADDR_WIDTH must lie between 10 and 32");
    end

    // byte address of a register index, at the bus width
    function automatic logic [ADDR_WIDTH-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_WIDTH'({idx, 2'b00});
    endfunction

    // one-hot register select from an address; all zero when unmapped
    function automatic logic [REG_COUNT-1:0] reg_select(
        input logic [ADDR_WIDTH-1:0] addr
    );
        reg_select[0] = (addr == byte_addr(`MLTR_IDX_CURRENT_GAIN));
        reg_select[1] = (addr == byte_addr(`MLTR_IDX_SPEED_GAIN));
        reg_select[2] = (addr == byte_addr(`MLTR_IDX_PROFILE_FIRST));
    endfunction

    // merge write data into a register under the byte strobes
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0]  lanes
    );
        for (int b = 0; b < 4; b++) begin
            merge_lanes[b*8 +: 8] = lanes[b] ? new_value[b*8 +: 8]
                                             : old_value[b*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    logic [31:0]          cfg_reg [REG_COUNT];
    logic [31:0]          cfg_next [REG_COUNT];
    logic [31:0]          prdata_reg;
    logic [31:0]          prdata_next;
    logic                 pready_reg;
    logic                 pslverr_reg;
    logic                 pslverr_next;
    logic [REG_COUNT-1:0] addr_sel;
    logic                 setup_phase;
    logic                 write_fire;
    logic                 addr_mapped;

    assign addr_sel    = reg_select(paddr);
    assign addr_mapped = |addr_sel;
    assign setup_phase = psel && !penable;
    // writes land only on the access edge that the slave completes
    assign write_fire  = psel && penable && pwrite && pready_reg;

    // read data is picked in the setup cycle so pready can be a flop;
    // reading has no effect on any register
    assign prdata_next  = addr_sel[0] ? cfg_reg[0] :        // RL13
                          addr_sel[1] ? cfg_reg[1] :
                          addr_sel[2] ? cfg_reg[2] : `MLTR_RESET_VALUE;
    assign pslverr_next = setup_phase && !addr_mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= `MLTR_RESET_VALUE;
        end else begin
            // one wait-free access phase follows every setup cycle
            pready_reg  <= setup_phase;
            pslverr_reg <= pslverr_next;
            if (setup_phase && !pwrite) begin
                prdata_reg <= prdata_next;
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------------
    // storage; all 32 bits of each word read back as written
    // ------------------------------------------------------------------
    for (genvar r = 0; r < REG_COUNT; r++) begin : g_cfg
        assign cfg_next[r] = (write_fire && addr_sel[r])
                           ? merge_lanes(cfg_reg[r], pwdata, pstrb)  // RL13
                           : cfg_reg[r];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_reg[r] <= `MLTR_RESET_VALUE;                     // RL1
            end else begin
                cfg_reg[r] <= cfg_next[r];
            end
        end

        // parity bit is stored only; its checking lives elsewhere
        assign parity_bits[r] = cfg_reg[r][`MLTR_PARITY_BIT];
    end

    // ------------------------------------------------------------------
    // field views for the control algorithm
    // ------------------------------------------------------------------
    assign loop_cfg.back_emf_constant_code =
        cfg_reg[0][`MLTR_BEMF_MSB:`MLTR_BEMF_LSB];                     // RL2
    assign loop_cfg.current_prop_gain =
        cfg_reg[0][`MLTR_CUR_KP_MSB:`MLTR_CUR_KP_LSB];                 // RL3
    assign loop_cfg.current_integ_gain =
        cfg_reg[0][`MLTR_CUR_KI_MSB:`MLTR_CUR_KI_LSB];                 // RL4
    assign loop_cfg.speed_prop_gain = {
        cfg_reg[0][`MLTR_SPD_KP_HI_MSB:`MLTR_SPD_KP_HI_LSB],
        cfg_reg[1][`MLTR_SPD_KP_LO_MSB:`MLTR_SPD_KP_LO_LSB]};          // RL6
    assign loop_cfg.speed_integ_gain =
        cfg_reg[1][`MLTR_SPD_KI_MSB:`MLTR_SPD_KI_LSB];                 // RL8
    assign loop_cfg.max_speed_code =
        cfg_reg[1][`MLTR_MAX_SPEED_MSB:`MLTR_MAX_SPEED_LSB];           // RL9

    // all four selector codes are legal, so the cast needs no check
    assign profile_cfg.mode = mltr_profile_mode_type'(
        cfg_reg[2][`MLTR_PROF_MODE_MSB:`MLTR_PROF_MODE_LSB]);          // RL11
    assign profile_cfg.turn_on_duty_threshold =
        cfg_reg[2][`MLTR_DUTY_ON_MSB:`MLTR_DUTY_ON_LSB];               // RL12
    assign profile_cfg.turn_off_duty_threshold =
        cfg_reg[2][`MLTR_DUTY_OFF_MSB:`MLTR_DUTY_OFF_LSB];             // RL12
    assign profile_cfg.clamp_duty_threshold =
        cfg_reg[2][`MLTR_DUTY_CLAMP_MSB:`MLTR_DUTY_CLAMP_LSB];         // RL12
    assign profile_cfg.duty_a_upper =
        cfg_reg[2][`MLTR_DUTY_A_HI_MSB:`MLTR_DUTY_A_HI_LSB];           // RL10

    // ------------------------------------------------------------------
    // gain decoding, registered so the outputs stay glitch free;
    // this costs one cycle of lag behind the stored word
    // ------------------------------------------------------------------
    logic [9:0]    gain_code [`MLTR_GAIN_COUNT];
    mltr_gain_type gain_split [`MLTR_GAIN_COUNT];
    mltr_gain_type gain_reg [`MLTR_GAIN_COUNT];
    logic          auto_next;
    logic          auto_reg;

    assign gain_code[0] = loop_cfg.current_prop_gain;
    assign gain_code[1] = loop_cfg.current_integ_gain;
    assign gain_code[2] = loop_cfg.speed_prop_gain;
    assign gain_code[3] = loop_cfg.speed_integ_gain;

    for (genvar g = 0; g < `MLTR_GAIN_COUNT; g++) begin : g_gain
        mltr_gain_split u_split (
            .gain_code (gain_code[g]),
            .gain      (gain_split[g])
        );

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                gain_reg[g] <= '0;
            end else begin
                gain_reg[g] <= gain_split[g];                 // RL7
            end
        end

        assign gain_decoded[g] = gain_reg[g];
    end

    // either current gain left at zero hands both to auto calculation
    assign auto_next = gain_split[0].zero || gain_split[1].zero;   // RL5

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_reg <= 1'b0;
        end else begin
            auto_reg <= auto_next;
        end
    end

    assign current_gain_auto = auto_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic full_write;
    assign full_write = write_fire && (pstrb == 4'hf);

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_access_s;
        psel && penable && pready;
    endsequence

    reset_zero_a: assert property (                                // RL1
        $rose(presetn) |-> (cfg_reg[0] == `MLTR_RESET_VALUE)
            && (cfg_reg[1] == `MLTR_RESET_VALUE)
            && (cfg_reg[2] == `MLTR_RESET_VALUE))
        else $error("register not zero after reset");

    apb_timing_a: assert property (
        apb_setup_s |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");

    write_store_a: assert property (                               // RL13
        full_write && addr_sel[0] |=> cfg_reg[0] == $past(pwdata))
        else $error("written word not stored");

    read_back_a: assert property (                                 // RL13
        apb_setup_s and (!pwrite && addr_sel[1])
        |=> apb_access_s and (prdata == $past(cfg_reg[1])))
        else $error("read data differs from stored word");

    bemf_field_a: assert property (                                // RL2
        full_write && addr_sel[0]
        |=> loop_cfg.back_emf_constant_code == $past(pwdata[30:23]))
        else $error("back-EMF code not at bits 30..23");

    cur_prop_gain_a: assert property (                             // RL3
        full_write && addr_sel[0]
        |-> ##2 {gain_decoded[0].exponent, gain_decoded[0].mantissa}
                == $past(pwdata[22:13], 2))
        else $error("current proportional gain misdecoded");

    cur_integ_gain_a: assert property (                            // RL4
        full_write && addr_sel[0]
        |-> ##2 {gain_decoded[1].exponent, gain_decoded[1].mantissa}
                == $past(pwdata[12:3], 2))
        else $error("current integral gain misdecoded");

    auto_select_a: assert property (                               // RL5
        (cfg_reg[0][22:13] == 10'h000 || cfg_reg[0][12:3] == 10'h000)
        |=> current_gain_auto)
        else $error("zero current gain did not select auto");

    spd_prop_join_a: assert property (                             // RL6
        1'b1 |=> {gain_decoded[2].exponent, gain_decoded[2].mantissa}
                 == {$past(cfg_reg[0][2:0]), $past(cfg_reg[1][30:24])})
        else $error("speed proportional gain halves misjoined");

    spd_integ_gain_a: assert property (                            // RL8
        1'b1 |=> gain_decoded[3].mantissa == $past(cfg_reg[1][21:14])
                 && gain_decoded[3].exponent == $past(cfg_reg[1][23:22]))
        else $error("speed integral gain misdecoded");

    max_speed_a: assert property (                                 // RL9
        full_write && addr_sel[1]
        |=> loop_cfg.max_speed_code == $past(pwdata[13:0]))
        else $error("maximum speed code not at bits 13..0");

    profile_mode_a: assert property (                              // RL11
        full_write && addr_sel[2]
        |=> profile_cfg.mode == mltr_profile_mode_type'($past(pwdata[30:29])))
        else $error("profile selector not at bits 30..29");

    duty_fields_a: assert property (                               // RL12
        full_write && addr_sel[2]
        |=> profile_cfg.turn_on_duty_threshold == $past(pwdata[28:21])
            && profile_cfg.turn_off_duty_threshold == $past(pwdata[20:13])
            && profile_cfg.clamp_duty_threshold == $past(pwdata[12:5]))
        else $error("duty threshold fields misplaced");

    read_quiet_a: assert property (                                // RL13
        psel && !pwrite |=> cfg_reg[2] == $past(cfg_reg[2]))
        else $error("read changed a register");

    refused_write_a: assert property (                             // RL13
        write_fire && !addr_mapped
        |=> cfg_reg[0] == $past(cfg_reg[0])
            && cfg_reg[1] == $past(cfg_reg[1])
            && cfg_reg[2] == $past(cfg_reg[2]))
        else $error("refused write changed a register");

    error_answer_a: assert property (
        apb_setup_s |=> pslverr == $past(!addr_mapped))
        else $error("error response does not follow the address map");

    lane_keep_a: assert property (                                 // RL13
        write_fire && addr_sel[1] && !pstrb[0]
        |=> cfg_reg[1][7:0] == $past(cfg_reg[1][7:0]))
        else $error("disabled byte lane was overwritten");

    auto_clear_a: assert property (                                // RL5
        (cfg_reg[0][22:13] != 10'h000 && cfg_reg[0][12:3] != 10'h000)
        |=> !current_gain_auto)
        else $error("nonzero current gains still select auto");

    zero_flag_a: assert property (                                 // RL5
        1'b1 |=> gain_decoded[1].zero
                 == ($past(cfg_reg[0][12:3]) == 10'h000))
        else $error("current integral zero flag wrong");

    duty_upper_a: assert property (                                // RL10
        full_write && addr_sel[2]
        |=> profile_cfg.duty_a_upper == $past(pwdata[4:0]))
        else $error("upper duty point A bits misplaced");

    parity_store_a: assert property (                              // RL13
        full_write && addr_sel[1]
        |=> parity_bits[1] == $past(pwdata[31]))
        else $error("parity bit not stored");

    read_quiet_low_a: assert property (                            // RL13
        psel && !pwrite
        |=> cfg_reg[0] == $past(cfg_reg[0])
            && cfg_reg[1] == $past(cfg_reg[1]))
        else $error("read changed a gain register");

endmodule

//--- test_motor_loop_tuning_regs.sv
// self-checking bench for the tuning register bank behind APB
`timescale 1ns/100ps
`include "mltr_cfg.svh"

module test_motor_loop_tuning_regs
    import mltr_pkg::*;
;
    typedef struct {
        int          r;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] q;
    } mltr_row_type;

    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata;
    logic [3:0]           pstrb;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    mltr_loop_cfg_type    loop_cfg;
    mltr_profile_cfg_type profile_cfg;
    mltr_gain_type [3:0]  gain_decoded;
    logic                 current_gain_auto;
    logic                 parity_bits [3];
    int                   errors;
    int                   comparisons;
    int                   cycles;
    logic [31:0]          sh [3];
    logic [11:0]          addr_of [3];
    mltr_row_type         rows [9];

    mltr_tuning_regs #(.ADDR_WIDTH(12)) i_mltr_tuning_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_cfg(loop_cfg), .profile_cfg(profile_cfg),
        .gain_decoded(gain_decoded),
        .current_gain_auto(current_gain_auto), .parity_bits(parity_bits)
    );

    always #5 pclk = ~pclk;

    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a hang on the bus must still reach the report
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors++;
            close_out();
        end
    end

    task automatic check(input string n, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask

    // one transfer; read data and response taken at the pready edge only
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic eexp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, 4'h0, q, e);
        check("read data", q, exp);
        check("read error", 32'(e), 32'(eexp));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, s, q, e);
        check("write error", 32'(e), 32'(a != addr_of[0] && a != addr_of[1]
              && a != addr_of[2]));
    endtask

    function automatic logic [10:0] gexp(input logic [9:0] c);
        return {c[7:0], c[9:8], (c == 10'h000)};
    endfunction

    // fields land on the edge that completes the write, decoded gains one cycle later
    task automatic check_fields;
        logic [9:0] spd_kp;
        spd_kp = {sh[0][2:0], sh[1][30:24]};
        repeat (3) @(posedge pclk);
        check("bemf", 32'(loop_cfg.back_emf_constant_code),
              32'(sh[0][30:23]));
        check("cur kp", 32'(loop_cfg.current_prop_gain),
              32'(sh[0][22:13]));
        check("cur ki", 32'(loop_cfg.current_integ_gain),
              32'(sh[0][12:3]));
        check("spd kp", 32'(loop_cfg.speed_prop_gain), 32'(spd_kp));
        check("spd ki", 32'(loop_cfg.speed_integ_gain),
              32'(sh[1][23:14]));
        check("max speed", 32'(loop_cfg.max_speed_code),
              32'(sh[1][13:0]));
        check("mode", 32'(profile_cfg.mode), 32'(sh[2][30:29]));
        check("duty", {3'h0, profile_cfg.turn_on_duty_threshold,
              profile_cfg.turn_off_duty_threshold,
              profile_cfg.clamp_duty_threshold, profile_cfg.duty_a_upper},
              {3'h0, sh[2][28:0]});
        check("dec cur kp", 32'(gain_decoded[0]),
              32'(gexp(sh[0][22:13])));
        check("dec cur ki", 32'(gain_decoded[1]),
              32'(gexp(sh[0][12:3])));
        check("dec spd kp", 32'(gain_decoded[2]), 32'(gexp(spd_kp)));
        check("dec spd ki", 32'(gain_decoded[3]),
              32'(gexp(sh[1][23:14])));
        check("auto", 32'(current_gain_auto), 32'((sh[0][22:13] == 0)
              || (sh[0][12:3] == 0)));
        for (int i = 0; i < 3; i++) begin
            check("parity", 32'(parity_bits[i]), 32'(sh[i][31]));
        end
    endtask

    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0000_0000;
        pstrb       = 4'h0;
        errors      = 0;
        comparisons = 0;
        cycles      = 0;
        addr_of[0]  = 12'(`MLTR_IDX_CURRENT_GAIN) << 2;
        addr_of[1]  = 12'(`MLTR_IDX_SPEED_GAIN) << 2;
        addr_of[2]  = 12'(`MLTR_IDX_PROFILE_FIRST) << 2;
        rows = '{
            '{0, 32'hFFFF_FFFF, 4'hf, 32'hFFFF_FFFF},
            '{0, 32'h0000_0000, 4'h3, 32'hFFFF_0000},
            '{0, 32'h5A5A_A5A5, 4'hf, 32'h5A5A_A5A5},
            '{0, 32'h0000_2000, 4'hf, 32'h0000_2000},
            '{1, 32'hAAAA_5555, 4'hf, 32'hAAAA_5555},
            '{1, 32'h1234_5678, 4'hc, 32'h1234_5555},
            '{1, 32'h0000_2710, 4'hf, 32'h0000_2710},
            '{2, 32'h8765_4321, 4'hf, 32'h8765_4321},
            '{2, 32'h0000_00FF, 4'h1, 32'h8765_43FF}
        };
        repeat (5) @(posedge pclk);
        check("reset loop", 32'(loop_cfg), 32'h0000_0000);
        check("reset auto", 32'(current_gain_auto), 32'h0000_0000);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            sh[i] = 32'h0000_0000;
            rd_chk(addr_of[i], 32'h0000_0000, 1'b0);
        end
        check_fields();
        foreach (rows[k]) begin
            wr(addr_of[rows[k].r], rows[k].d, rows[k].s);
            sh[rows[k].r] = rows[k].q;
            rd_chk(addr_of[rows[k].r], rows[k].q, 1'b0);
            check_fields();
        end
        for (int m = 0; m < 4; m++) begin
            sh[2] = {1'b0, 2'(m), 29'h0ABC_DE12};
            wr(addr_of[2], sh[2], 4'hf);
            check_fields();
        end
        // unmapped and misaligned places refuse and leave state alone
        rd_chk(12'h240, 32'h0000_0000, 1'b1);
        wr(12'h240, 32'hFFFF_FFFF, 4'hf);
        wr(addr_of[0] + 12'h001, 32'h0000_0000, 4'hf);
        rd_chk(addr_of[0], sh[0], 1'b0);
        rd_chk(addr_of[0], sh[0], 1'b0);
        check_fields();
        // reset in mid-run clears everything again
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("rerun loop", 32'(loop_cfg), 32'h0000_0000);
        check("rerun prof", 32'(profile_cfg), 32'h0000_0000);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            sh[i] = 32'h0000_0000;
            rd_chk(addr_of[i], 32'h0000_0000, 1'b0);
        end
        check_fields();
        close_out();
    end
endmodule
